/* File: inc/supply_ctrl_pkg.sv */
package supply_ctrl_pkg;

    // ==========================================================
    // timebase
    // ==========================================================
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

    // ==========================================================
    // times in milliseconds
    // ==========================================================
    localparam int unsigned T_ON_MIN_MS = 5;
    localparam int unsigned T_ON_MAX_MS = 400;
    localparam int unsigned T_ON_USE_MS = 20;
    localparam int unsigned T_PG_OFF_MAX_MS = 50;
    localparam int unsigned T_PG_ON_MIN_MS = 100;
    localparam int unsigned T_PG_ON_MAX_MS = 500;
    localparam int unsigned T_PG_ON_USE_MS = 200;
    localparam int unsigned T_PD_LEAD_MIN_MS = 1;
    localparam int unsigned T_PD_LEAD_MAX_MS = 200;
    localparam int unsigned T_PD_LEAD_USE_MS = 10;
    localparam int unsigned T_BLINK_MS = 500;
    localparam int unsigned T_RECOVER_MS = 1000;

    // ==========================================================
    // cycle counts derived from the times
    // ==========================================================
    localparam int unsigned ON_DELAY_CYC = T_ON_USE_MS * CYC_PER_MS;
    localparam int unsigned PG_DELAY_CYC = T_PG_ON_USE_MS * CYC_PER_MS;
    localparam int unsigned PD_LEAD_CYC = T_PD_LEAD_USE_MS * CYC_PER_MS;
    localparam int unsigned BLINK_HALF_CYC = T_BLINK_MS * CYC_PER_MS;
    localparam int unsigned RECOVER_CYC = T_RECOVER_MS * CYC_PER_MS;
    localparam int unsigned CNT_W = 26;

    // ==========================================================
    // types
    // ==========================================================
    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_RAMP = 3'b001,
        ST_PG_WAIT = 3'b010,
        ST_ON = 3'b011,
        ST_PD_LEAD = 3'b100,
        ST_LATCHED = 3'b101
    } seq_state_t;

    typedef struct packed {
        logic ac_ok;
        logic rails_in_reg;
        logic cur_limit;
        logic fail;
        logic warn;
        logic latch_fault;
    } supply_status_t;

    typedef struct packed {
        logic green;
        logic red;
    } led_t;

endpackage

/* File: rtl/ms_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module ms_timer
    import supply_ctrl_pkg::*;
#(
    parameter int unsigned W = CNT_W
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_run,
    input wire logic [W-1:0] i_limit,
    output logic o_done
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    // ==========================================================
    // counter: clears while not running, holds at limit
    // ==========================================================
    always_comb begin
        cnt_nxt = cnt_r;
        if (!i_run) begin
            cnt_nxt = '0;
        end else if (cnt_r != i_limit) begin
            cnt_nxt = cnt_r + 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign o_done = i_run && (cnt_r == i_limit);
endmodule
`default_nettype wire

/* File: rtl/supply_onoff_status_control.sv */
`timescale 1ns/100ps
`default_nettype none
// Operation
// [R01] mains on only with request and kill low
// [R02] request released keeps mains off
// [R03] kill open keeps mains off
// [R04] standby rails stay on always
// [R05] mains rise 5 to 400 ms after request
// [R06] power-good drops within 50 ms of release
// [R07] power-good high only while rails regulate
// [R08] power-good low on dropout or input loss
// [R09] current limit holds off power-good delay
// [R10] power-good 100 to 500 ms after regulation
// [R11] power-good leads power-down by 1-200 ms
// [R12] no input: green off, red blinks
// [R13] outputs off: green blinks, red off
// [R14] outputs on, healthy: green steady
// [R15] failure: green off, red steady
// [R16] warning: green and amber alternate each second; the code alternates green with red, never amber
// [R17] alarm on module failure or power-good loss
// [R18] alarm holds until power-good or button
// [R19] request high one second clears latch
// [R20] delays counted on fixed clock
module supply_onoff_status_control
    import supply_ctrl_pkg::*;
#(
    parameter int unsigned ON_DELAY = ON_DELAY_CYC,
    parameter int unsigned PG_DELAY = PG_DELAY_CYC,
    parameter int unsigned PD_LEAD = PD_LEAD_CYC,
    parameter int unsigned BLINK_HALF = BLINK_HALF_CYC,
    parameter int unsigned RECOVER = RECOVER_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_pwr_on_req_n,
    input wire logic i_supply_kill_sense,
    input wire supply_status_t i_status,
    input wire logic i_peer_fail,
    input wire logic i_peer_pg,
    input wire logic i_alarm_reset,
    output logic o_main_en,
    output logic o_standby_en,
    output logic o_power_good,
    output led_t o_led,
    output logic o_alarm
);
    // ==========================================================
    // reset release
    // ==========================================================
    logic rst_s1_r;
    logic rst_n_r;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    // ==========================================================
    // request decode
    // ==========================================================
    logic want_on;
    // kill sense high means open, which refuses the request
    assign want_on = !i_pwr_on_req_n && !i_supply_kill_sense; // see [R01] see [R02] see [R03]

    // ==========================================================
    // timers
    // ==========================================================
    logic on_run;
    logic pg_run;
    logic pd_run;
    logic rec_run;
    logic on_done;
    logic pg_done;
    logic pd_done;
    logic rec_done;
    seq_state_t st_r;
    seq_state_t st_nxt;

    assign on_run = (st_r == ST_RAMP);
    assign pg_run = (st_r == ST_PG_WAIT) && i_status.rails_in_reg
        && !i_status.cur_limit; // see [R09]
    assign pd_run = (st_r == ST_PD_LEAD);
    assign rec_run = (st_r == ST_LATCHED) && i_pwr_on_req_n;

    ms_timer u_on_tmr (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(rst_n_r),
        .i_run(on_run),
        .i_limit(CNT_W'(ON_DELAY)),
        .o_done(on_done)
    ); // see [R05] see [R20]

    ms_timer u_pg_tmr (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(rst_n_r),
        .i_run(pg_run),
        .i_limit(CNT_W'(PG_DELAY)),
        .o_done(pg_done)
    ); // see [R10]

    ms_timer u_pd_tmr (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(rst_n_r),
        .i_run(pd_run),
        .i_limit(CNT_W'(PD_LEAD)),
        .o_done(pd_done)
    ); // see [R11]

    ms_timer u_rec_tmr (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(rst_n_r),
        .i_run(rec_run),
        .i_limit(CNT_W'(RECOVER)),
        .o_done(rec_done)
    ); // see [R19]

    // ==========================================================
    // sequencer
    // ==========================================================
    logic main_en_r;
    logic main_en_nxt;
    logic pg_r;
    logic pg_nxt;
    logic rec_seen_r;
    logic rec_seen_nxt;

    always_comb begin
        st_nxt = st_r;
        main_en_nxt = main_en_r;
        pg_nxt = 1'b0;
        rec_seen_nxt = rec_seen_r;
        unique case (st_r)
            ST_OFF: begin
                main_en_nxt = 1'b0;
                if (want_on && i_status.ac_ok) begin
                    st_nxt = ST_RAMP;
                end
            end
            ST_RAMP: begin
                if (!want_on) begin
                    st_nxt = ST_OFF;
                end else if (on_done) begin
                    main_en_nxt = 1'b1; // see [R05]
                    st_nxt = ST_PG_WAIT;
                end
            end
            ST_PG_WAIT: begin
                if (!want_on || !i_status.ac_ok) begin
                    st_nxt = ST_PD_LEAD;
                end else if (pg_done) begin
                    pg_nxt = 1'b1;
                    st_nxt = ST_ON;
                end
            end
            ST_ON: begin
                pg_nxt = i_status.rails_in_reg; // see [R07] see [R08]
                if (!want_on || !i_status.ac_ok) begin
                    pg_nxt = 1'b0; // see [R06] see [R08]
                    st_nxt = ST_PD_LEAD;
                end else if (!i_status.rails_in_reg) begin
                    st_nxt = ST_PG_WAIT;
                end
            end
            ST_PD_LEAD: begin
                // mains held on so power-good leads them down
                if (pd_done) begin
                    main_en_nxt = 1'b0; // see [R11]
                    st_nxt = ST_OFF;
                end
            end
            ST_LATCHED: begin
                main_en_nxt = 1'b0;
                // recovery needs a full released period first
                if (rec_done) begin
                    rec_seen_nxt = 1'b1;
                end
                if (rec_seen_r && !i_pwr_on_req_n && !i_status.latch_fault) begin
                    rec_seen_nxt = 1'b0; // see [R19]
                    st_nxt = ST_OFF;
                end
            end
            default: begin
                st_nxt = ST_OFF;
                main_en_nxt = 1'b0;
            end
        endcase
        // a latched fault overrides every state
        if (i_status.latch_fault && st_r != ST_LATCHED) begin
            st_nxt = ST_LATCHED;
            main_en_nxt = 1'b0;
            pg_nxt = 1'b0;
            rec_seen_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            st_r <= ST_OFF;
            main_en_r <= 1'b0;
            pg_r <= 1'b0;
            rec_seen_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            main_en_r <= main_en_nxt;
            pg_r <= pg_nxt;
            rec_seen_r <= rec_seen_nxt;
        end
    end

    assign o_main_en = main_en_r;
    assign o_power_good = pg_r;
    assign o_standby_en = 1'b1; // see [R04]

    // ==========================================================
    // blink timebase: toggles every half second
    // ==========================================================
    logic [CNT_W-1:0] blink_cnt_r;
    logic [CNT_W-1:0] blink_cnt_nxt;
    logic phase_r;
    logic phase_nxt;

    always_comb begin
        blink_cnt_nxt = blink_cnt_r + 1'b1;
        phase_nxt = phase_r;
        if (blink_cnt_r == CNT_W'(BLINK_HALF - 1)) begin
            blink_cnt_nxt = '0;
            phase_nxt = !phase_r; // see [R20]
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            blink_cnt_r <= '0;
            phase_r <= 1'b0;
        end else begin
            blink_cnt_r <= blink_cnt_nxt;
            phase_r <= phase_nxt;
        end
    end

    // ==========================================================
    // indicator and alarm
    // ==========================================================
    led_t led_nxt;
    led_t led_r;
    logic alarm_r;
    logic alarm_nxt;
    logic outputs_on;
    logic pg_lost;

    assign outputs_on = main_en_r;
    // own power-good falling while still asked to run
    assign pg_lost = pg_r && !pg_nxt && want_on; // see [R17]

    always_comb begin
        led_nxt = '0;
        if (!i_status.ac_ok) begin
            led_nxt.red = phase_r; // see [R12]
        end else if (i_status.fail || i_status.latch_fault) begin
            led_nxt.red = 1'b1; // see [R15]
        end else if (!outputs_on) begin
            led_nxt.green = phase_r; // see [R13]
        end else if (i_status.warn) begin
            led_nxt.green = phase_r; // see [R16]
            led_nxt.red = !phase_r;
        end else begin
            led_nxt.green = 1'b1; // see [R14]
        end
    end

    always_comb begin
        alarm_nxt = alarm_r;
        if (i_alarm_reset || (pg_r && i_peer_pg && !i_status.fail && !i_peer_fail)) begin
            alarm_nxt = 1'b0; // see [R18]
        end
        // the button wins while it is held
        if ((i_peer_fail || i_status.fail || (!i_peer_pg && i_status.ac_ok) || pg_lost)
                && !i_alarm_reset) begin
            alarm_nxt = 1'b1; // see [R17]
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            led_r <= '0;
        end else begin
            led_r <= led_nxt;
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            alarm_r <= 1'b0;
        end else begin
            alarm_r <= alarm_nxt;
        end
    end

    assign o_led = led_r;
    assign o_alarm = alarm_r;
endmodule
`default_nettype wire

/* File: bench/supply_ctrl_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module supply_ctrl_checker
    import supply_ctrl_pkg::*;
#(
    parameter int unsigned ON_DELAY = ON_DELAY_CYC,
    parameter int unsigned PG_DELAY = PG_DELAY_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_pwr_on_req_n,
    input wire logic i_supply_kill_sense,
    input wire supply_status_t i_status,
    input wire logic i_peer_fail,
    input wire logic i_peer_pg,
    input wire logic i_alarm_reset,
    input wire logic o_main_en,
    input wire logic o_standby_en,
    input wire logic o_power_good,
    input wire led_t o_led,
    input wire logic o_alarm
);
    // ==========================================================
    // run lengths of request and of clean regulation
    // ==========================================================
    logic want;
    logic [CNT_W-1:0] want_r, want_nxt, reg_r, reg_nxt;
    assign want = !i_pwr_on_req_n && !i_supply_kill_sense;
    always_comb begin
        want_nxt = want ? want_r + 1'b1 : '0;
        reg_nxt = (i_status.rails_in_reg && !i_status.cur_limit) ? reg_r + 1'b1 : '0;
    end
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            want_r <= '0;
            reg_r <= '0;
        end else begin
            want_r <= want_nxt;
            reg_r <= reg_nxt;
        end
    end
    // ==========================================================
    // assertions
    // ==========================================================
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    main_req_a: assert property ($rose(o_main_en) |-> $past(want))
        else $error("main on unasked");
    main_off_a: assert property (!o_main_en && !want |=> !o_main_en)
        else $error("main on");
    standby_on_a: assert property (o_standby_en)
        else $error("standby off");
    on_delay_a: assert property ($rose(o_main_en) |->
        want_r >= ON_DELAY && want_r <= ON_DELAY + 6) else $error("on delay");
    pg_drop_a: assert property ($rose(i_pwr_on_req_n) && o_power_good |->
        ##[1:2] !o_power_good) else $error("pg late");
    pg_rails_a: assert property (o_power_good |-> $past(i_status.rails_in_reg))
        else $error("pg no rails");
    pg_delay_a: assert property ($rose(o_power_good) |-> reg_r >= PG_DELAY)
        else $error("pg early");
    pg_lead_a: assert property ($fell(o_power_good) && $past(i_pwr_on_req_n) |->
        o_main_en [*8]) else $error("no lead");
    fail_led_a: assert property ((i_status.ac_ok && i_status.fail) [*3] |->
        !o_led.green && o_led.red) else $error("fail led");
    alarm_quiet_a: assert property (i_alarm_reset [*2] |-> !o_alarm)
        else $error("alarm on");
    cover property ($rose(o_power_good));
    cover property ($rose(o_alarm));
    cover property (i_status.warn && o_power_good);
endmodule
bind supply_onoff_status_control supply_ctrl_checker #(
    .ON_DELAY(ON_DELAY),
    .PG_DELAY(PG_DELAY)
) u_chk (.*);
`default_nettype wire

/* File: bench/host_board_model.sv */
`timescale 1ns/100ps
`default_nettype none
module host_board_model (
    input wire logic i_ref_clk,
    input wire logic i_on,
    input wire logic i_kill_open,
    input wire logic i_main_en,
    output logic o_req_n,
    output logic o_kill,
    output logic o_rails_ok
);
    logic [1:0] ramp_r;
    // released open-drain lines read high through the pull-ups
    initial begin
        o_req_n = 1'b1;
        o_kill = 1'b1;
        o_rails_ok = 1'b0;
        ramp_r = 2'b00;
    end
    always @(posedge i_ref_clk) begin
        o_req_n <= !i_on;
        o_kill <= i_kill_open;
        ramp_r <= i_main_en ? {ramp_r[0], 1'b1} : 2'b00;
        o_rails_ok <= ramp_r[1];
    end
endmodule
`default_nettype wire

/* File: bench/test_supply_onoff_status_control.sv */
`timescale 1ns/100ps
`default_nettype none
module test_supply_onoff_status_control import supply_ctrl_pkg::*;;
    localparam int ON_D = 20;
    localparam int PG_D = 40;
    localparam int PD_D = 10;
    localparam int BL_D = 8;
    localparam int RC_D = 30;
    logic clk = 1'b0, rst_n = 1'b0, on = 1'b0, kopen = 1'b0, ac = 1'b1;
    logic cl = 1'b0, fl = 1'b0, wn = 1'b0, lf = 1'b0, pfail = 1'b0, arst = 1'b0;
    logic ppg = 1'b1, g0;
    logic req_n, kill, rails, main_en, stby, pg, alarm;
    led_t led;
    supply_status_t status;
    int fails = 0;
    int check_count = 0;
    int n;
    assign status = {ac, rails, cl, fl, wn, lf};
    always #20 clk = ~clk;
    host_board_model u_host (.i_ref_clk(clk), .i_on(on), .i_kill_open(kopen),
        .i_main_en(main_en), .o_req_n(req_n), .o_kill(kill), .o_rails_ok(rails));
    supply_onoff_status_control #(.ON_DELAY(ON_D), .PG_DELAY(PG_D), .PD_LEAD(PD_D),
        .BLINK_HALF(BL_D), .RECOVER(RC_D)) u_dut (.i_ref_clk(clk), .i_nrst(rst_n),
        .i_pwr_on_req_n(req_n), .i_supply_kill_sense(kill), .i_status(status),
        .i_peer_fail(pfail), .i_peer_pg(ppg), .i_alarm_reset(arst), .o_main_en(main_en),
        .o_standby_en(stby), .o_power_good(pg), .o_led(led), .o_alarm(alarm));
    task automatic report_and_stop();
        if (fails == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic bad(input string m);
        fails++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task automatic cmp(input logic got, input logic exp);
        check_count++;
        if (got !== exp) bad("level wrong");
    endtask
    task automatic cmp_led(input led_t got, input led_t exp);
        check_count++;
        if (got !== exp) bad("led wrong");
    endtask
    task automatic cmp_n(input int got, input int lo, input int hi);
        check_count++;
        if (got < lo || got > hi) bad("delay out of window");
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    // cycles until main enable (sel 0) or power-good (sel 1) shows v
    task automatic wait_for(input bit sel, input logic v);
        n = 0;
        while ((sel ? pg : main_en) !== v && n < 3000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 3000) bad("wait timed out");
    endtask
    task automatic t_refuse();
        @(posedge clk);
        on <= 1'b1;
        kopen <= 1'b1;
        cyc(2 * ON_D);
        cmp(main_en, 1'b0);
        @(posedge clk);
        on <= 1'b0;
        kopen <= 1'b0;
        cyc(2 * ON_D);
        cmp(main_en, 1'b0);
    endtask
    task automatic t_up();
        @(posedge clk);
        on <= 1'b1;
        wait_for(0, 1'b1);
        cmp_n(n, ON_D, ON_D + 6);
        wait_for(1, 1'b1);
        cmp_n(n, PG_D + 3, PG_D + 8);
        cyc(3);
        cmp_led(led, led_t'(2'b10));
        cmp(stby, 1'b1);
    endtask
    task automatic t_down();
        @(posedge clk);
        on <= 1'b0;
        wait_for(1, 1'b0);
        cmp_n(n, 1, 4);
        wait_for(0, 1'b0);
        cmp_n(n, PD_D - 2, PD_D + 4);
    endtask
    task automatic t_limit();
        @(posedge clk);
        cl <= 1'b1;
        on <= 1'b1;
        wait_for(0, 1'b1);
        cyc(PG_D + 10);
        cmp(pg, 1'b0);
        @(posedge clk);
        cl <= 1'b0;
        wait_for(1, 1'b1);
        cmp_n(n, PG_D, PG_D + 4);
    endtask
    task automatic t_warn();
        @(posedge clk);
        wn <= 1'b1;
        cyc(3);
        g0 = led.green;
        cmp(led.red, !g0);
        cyc(BL_D);
        cmp(led.green, !g0);
        cmp(led.red, g0);
        @(posedge clk);
        wn <= 1'b0;
    endtask
    task automatic t_fail();
        @(posedge clk);
        fl <= 1'b1;
        cyc(3);
        cmp_led(led, led_t'(2'b01));
        cmp(alarm, 1'b1);
        @(posedge clk);
        arst <= 1'b1;
        fl <= 1'b0;
        pfail <= 1'b1;
        on <= 1'b0;
        cyc(2);
        cmp(alarm, 1'b0);
        @(posedge clk);
        arst <= 1'b0;
        cyc(3);
        cmp(alarm, 1'b1);
        @(posedge clk);
        pfail <= 1'b0;
        wait_for(0, 1'b0);
    endtask
    task automatic t_leds();
        cyc(3);
        g0 = led.green;
        cyc(BL_D);
        cmp(led.green, !g0);
        cmp(led.red, 1'b0);
        @(posedge clk);
        ac <= 1'b0;
        cyc(3);
        g0 = led.red;
        cmp(led.green, 1'b0);
        cyc(BL_D);
        cmp(led.red, !g0);
        @(posedge clk);
        ac <= 1'b1;
    endtask
    task automatic t_latch();
        @(posedge clk);
        on <= 1'b1;
        wait_for(1, 1'b1);
        cyc(2);
        cmp(alarm, 1'b0);
        @(posedge clk);
        ppg <= 1'b0;
        cyc(2);
        cmp(alarm, 1'b1);
        @(posedge clk);
        ppg <= 1'b1;
        cyc(2);
        cmp(alarm, 1'b0);
        @(posedge clk);
        lf <= 1'b1;
        wait_for(0, 1'b0);
        cmp(pg, 1'b0);
        cmp(alarm, 1'b1);
        @(posedge clk);
        lf <= 1'b0;
        cyc(2 * ON_D);
        cmp(main_en, 1'b0);
        @(posedge clk);
        on <= 1'b0;
        cyc(RC_D + 4);
        @(posedge clk);
        on <= 1'b1;
        wait_for(0, 1'b1);
        cmp_n(n, ON_D, ON_D + 6);
    endtask
    initial begin
        cyc(1);
        cmp(stby, 1'b1);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        cyc(4);
        t_refuse();
        t_up();
        t_down();
        t_limit();
        t_warn();
        t_fail();
        t_leds();
        t_latch();
        report_and_stop();
    end
    initial begin
        #(40 * 20000);
        fails++;
        report_and_stop();
    end
endmodule
`default_nettype wire
